// >>> rtl/drb_pkg.sv
// constants and types shared by the deterministic release buffer
package drb_pkg;
  localparam int unsigned      CLK_RATE_HZ       = 10000000;
  localparam int unsigned      OCTET_W           = 8;
  localparam int unsigned      OCTETS_PER_BEAT   = 4;
  localparam int unsigned      BEAT_W            = OCTET_W * OCTETS_PER_BEAT;
  localparam int unsigned      FRAME_MAX         = 32;
  localparam int unsigned      CNT_W             = 6;
  localparam int unsigned      PERIOD_W          = 4;
  localparam int unsigned      BUF_DEPTH         = 256;
  localparam int unsigned      BUF_AW            = 8;
  localparam int unsigned      SKID_DEPTH        = 2;
  // register map, one aligned word each
  localparam logic [7:0]       ADDR_FRAMES       = 8'h00;
  localparam logic [7:0]       ADDR_OFFSET       = 8'h04;
  localparam logic [7:0]       ADDR_PERIOD       = 8'h08;
  localparam logic [7:0]       ADDR_CTRL         = 8'h0C;
  localparam logic [7:0]       ADDR_STATUS       = 8'h10;
  localparam logic [7:0]       ADDR_EARLY        = 8'h14;
  localparam logic [7:0]       ADDR_EXTRA        = 8'h18;
  localparam logic [7:0]       ADDR_LATENCY      = 8'h1C;
  localparam logic [CNT_W-1:0] RST_FRAMES        = 6'h20;
  localparam logic [CNT_W-1:0] RST_OFFSET        = 6'h20;
  localparam logic [PERIOD_W-1:0] RST_PERIOD     = 4'h1;
  localparam logic [15:0]      RST_EXTRA         = 16'h0000;
  localparam int unsigned      CTRL_ENABLE_BIT   = 0;
  localparam int unsigned      STAT_ARMED_BIT    = 0;
  localparam int unsigned      STAT_RUN_BIT      = 1;
  localparam int unsigned      STAT_OVF_BIT      = 2;
  localparam int unsigned      STAT_CFG_BIT      = 3;
  typedef enum logic [1:0] {
    DRB_IDLE    = 2'b00,
    DRB_ARMED   = 2'b01,
    DRB_WAIT    = 2'b10,
    DRB_RUN     = 2'b11
  } drb_state_t;
endpackage

// >>> rtl/drb_skid.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module drb_skid (
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire logic [drb_pkg::BEAT_W-1:0] in_data,
  input  wire logic                      in_valid,
  output logic                           in_ready,
  output logic [drb_pkg::BEAT_W-1:0]     out_data,
  output logic                           out_valid,
  input  wire logic                      out_ready
);
  logic [drb_pkg::BEAT_W-1:0] mem [drb_pkg::SKID_DEPTH];
  logic [drb_pkg::BEAT_W-1:0] next_mem [drb_pkg::SKID_DEPTH];
  logic       rd_ptr;
  logic       wr_ptr;
  logic [1:0] count;
  logic       next_rd_ptr;
  logic       next_wr_ptr;
  logic [1:0] next_count;
  logic       push;
  logic       pop;

  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_mem    = mem;
    next_rd_ptr = rd_ptr;
    next_wr_ptr = wr_ptr;
    next_count  = count;
    if (push) begin
      next_mem[wr_ptr] = in_data;
      next_wr_ptr      = ~wr_ptr;
    end
    if (pop) begin
      next_rd_ptr = ~rd_ptr;
    end
    if (push && !pop) begin
      next_count = count + 2'h1;
    end else if (pop && !push) begin
      next_count = count - 2'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count  <= 2'h0;
      mem[0] <= '0;
      mem[1] <= '0;
    end else begin
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      count  <= next_count;
      mem    <= next_mem;
    end
  end

  a_skid_no_loss: assert property (@(posedge clk) disable iff (!reset_n)
    (count == 2'h2) && !out_ready |=> (count == 2'h2) && $stable(out_data))
    else $error("held word changed while stalled");
endmodule
`default_nettype wire

// >>> rtl/drb_release.sv
// elastic buffer whose release is tied to the local multiframe boundary
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - lane words wait in an elastic buffer until the programmed release offset
// - frames per multiframe sets the local multiframe clock period
// - frames per multiframe above 32 is flagged invalid and never released
// - all timing counts frame clock cycles, one per clock here
// - a later period index above zero selects the release multiframe
// - offset equal to frames per multiframe releases exactly on a boundary
// - release lands index times frames plus offset after the reference boundary
// - smaller offset moves chosen and previous release moments earlier
// - sysref delay is applied outside; its shift is taken as given
// - sysref is captured on the falling clock edge
// - sysref sampling clock is used undivided
// - output presents four octets per clock beat
// - early release readback equals frames minus offset
// - extra unpack cycles are added to the reported total latency
module drb_release (
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire logic                       sysref,
  input  wire logic [drb_pkg::BEAT_W-1:0] lane_data,
  input  wire logic                       lane_valid,
  input  wire logic                       lane_start,
  output logic [drb_pkg::BEAT_W-1:0]      rx_data,
  output logic                            rx_valid,
  input  wire logic                       rx_ready,
  output logic                            multiframe_tick,
  output logic                            release_pulse,
  input  wire logic [7:0]                 reg_addr,
  input  wire logic [31:0]                reg_wdata,
  input  wire logic                       reg_write,
  input  wire logic                       reg_read,
  output logic [31:0]                     reg_rdata
);
  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [drb_pkg::CNT_W-1:0]    frames_per_mf;
  logic [drb_pkg::CNT_W-1:0]    buffer_release_offset;
  logic [drb_pkg::PERIOD_W-1:0] release_period;
  logic                         enable;
  logic [15:0]                  extra_cycles;
  logic [drb_pkg::CNT_W-1:0]    next_frames_per_mf;
  logic [drb_pkg::CNT_W-1:0]    next_buffer_release_offset;
  logic [drb_pkg::PERIOD_W-1:0] next_release_period;
  logic                         next_enable;
  logic [15:0]                  next_extra_cycles;
  logic [31:0]                  next_reg_rdata;
  logic                         cfg_ok;
  logic                         overflow;
  logic                         next_overflow;
  drb_pkg::drb_state_t          state;
  drb_pkg::drb_state_t          next_state;
  logic [15:0]                  latency_total;

  function automatic logic [31:0] zext6(input logic [drb_pkg::CNT_W-1:0] v);
    zext6 = {26'h0000000, v};
  endfunction

  assign cfg_ok = (frames_per_mf != 6'h00) && (frames_per_mf <= 6'(drb_pkg::FRAME_MAX))
                  && (buffer_release_offset != 6'h00)
                  && (buffer_release_offset <= frames_per_mf)
                  && (release_period != 4'h0);

  assign latency_total = 16'(release_period) * 16'(frames_per_mf)
                         + 16'(buffer_release_offset) + extra_cycles;

  always_comb begin
    next_frames_per_mf         = frames_per_mf;
    next_buffer_release_offset = buffer_release_offset;
    next_release_period        = release_period;
    next_enable                = enable;
    next_extra_cycles          = extra_cycles;
    next_reg_rdata             = 32'h00000000;
    if (reg_write) begin
      case (reg_addr)
        drb_pkg::ADDR_FRAMES: next_frames_per_mf = reg_wdata[drb_pkg::CNT_W-1:0];
        drb_pkg::ADDR_OFFSET: next_buffer_release_offset = reg_wdata[drb_pkg::CNT_W-1:0];
        drb_pkg::ADDR_PERIOD: next_release_period = reg_wdata[drb_pkg::PERIOD_W-1:0];
        drb_pkg::ADDR_CTRL:   next_enable = reg_wdata[drb_pkg::CTRL_ENABLE_BIT];
        drb_pkg::ADDR_EXTRA:  next_extra_cycles = reg_wdata[15:0];
        default: ;
      endcase
    end
    if (reg_read) begin
      case (reg_addr)
        drb_pkg::ADDR_FRAMES:  next_reg_rdata = zext6(frames_per_mf);
        drb_pkg::ADDR_OFFSET:  next_reg_rdata = zext6(buffer_release_offset);
        drb_pkg::ADDR_PERIOD:  next_reg_rdata = {28'h0000000, release_period};
        drb_pkg::ADDR_CTRL:    next_reg_rdata = {31'h00000000, enable};
        drb_pkg::ADDR_STATUS:  next_reg_rdata = {28'h0000000, cfg_ok, overflow,
                                                 state == drb_pkg::DRB_RUN,
                                                 state != drb_pkg::DRB_IDLE};
        drb_pkg::ADDR_EARLY:   next_reg_rdata = zext6(frames_per_mf - buffer_release_offset);
        drb_pkg::ADDR_EXTRA:   next_reg_rdata = {16'h0000, extra_cycles};
        drb_pkg::ADDR_LATENCY: next_reg_rdata = {16'h0000, latency_total};
        default:               next_reg_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      frames_per_mf         <= drb_pkg::RST_FRAMES;
      buffer_release_offset <= drb_pkg::RST_OFFSET;
      release_period        <= drb_pkg::RST_PERIOD;
      enable                <= 1'b0;
      extra_cycles          <= drb_pkg::RST_EXTRA;
      reg_rdata             <= 32'h00000000;
    end else begin
      frames_per_mf         <= next_frames_per_mf;
      buffer_release_offset <= next_buffer_release_offset;
      release_period        <= next_release_period;
      enable                <= next_enable;
      extra_cycles          <= next_extra_cycles;
      reg_rdata             <= next_reg_rdata;
    end
  end

  // ----------------------------------------------------------------
  // sysref capture and multiframe counter
  // ----------------------------------------------------------------
  logic                      sysref_fall;
  logic                      sysref_rise;
  logic                      sysref_prev;
  logic                      sysref_edge;
  logic [drb_pkg::CNT_W-1:0] mf_cnt;
  logic [drb_pkg::CNT_W-1:0] next_mf_cnt;
  logic                      mf_boundary;

  always_ff @(negedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sysref_fall <= 1'b0;
    end else begin
      sysref_fall <= sysref;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sysref_rise <= 1'b0;
      sysref_prev <= 1'b0;
    end else begin
      sysref_rise <= sysref_fall;
      sysref_prev <= sysref_rise;
    end
  end
  assign sysref_edge = sysref_rise && !sysref_prev;

  assign mf_boundary = (mf_cnt == frames_per_mf - 6'h01);
  always_comb begin
    next_mf_cnt = mf_cnt + 6'h01;
    if (sysref_edge || mf_boundary) begin
      next_mf_cnt = 6'h00;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mf_cnt          <= 6'h00;
      multiframe_tick <= 1'b0;
    end else begin
      mf_cnt          <= next_mf_cnt;
      multiframe_tick <= sysref_edge || mf_boundary;
    end
  end

  // ----------------------------------------------------------------
  // release state machine
  // ----------------------------------------------------------------
  logic [drb_pkg::PERIOD_W-1:0] period_cnt;
  logic [drb_pkg::PERIOD_W-1:0] next_period_cnt;
  logic                         offset_hit;
  logic                         fire;

  // offset point within the frame count
  assign offset_hit = (mf_cnt == buffer_release_offset - 6'h01);
  assign fire = (state == drb_pkg::DRB_WAIT) && offset_hit
                && (period_cnt == release_period);

  always_comb begin
    next_state      = state;
    next_period_cnt = period_cnt;
    case (state)
      drb_pkg::DRB_IDLE: begin
        if (enable && cfg_ok) begin
          next_state = drb_pkg::DRB_ARMED;
        end
      end
      drb_pkg::DRB_ARMED: begin
        if (lane_start && lane_valid) begin
          next_state      = drb_pkg::DRB_WAIT;
          next_period_cnt = 4'h0;
        end
      end
      drb_pkg::DRB_WAIT: begin
        if (fire) begin
          next_state = drb_pkg::DRB_RUN;
        end else if (mf_boundary) begin
          next_period_cnt = period_cnt + 4'h1;
        end
      end
      drb_pkg::DRB_RUN: ;
      default: next_state = drb_pkg::DRB_IDLE;
    endcase
    if (!enable || !cfg_ok) begin
      next_state = drb_pkg::DRB_IDLE;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state         <= drb_pkg::DRB_IDLE;
      period_cnt    <= 4'h0;
      release_pulse <= 1'b0;
    end else begin
      state         <= next_state;
      period_cnt    <= next_period_cnt;
      release_pulse <= fire;
    end
  end

  // ----------------------------------------------------------------
  // elastic buffer
  // ----------------------------------------------------------------
  logic [drb_pkg::BEAT_W-1:0] ebuf [drb_pkg::BUF_DEPTH];
  logic [drb_pkg::BUF_AW:0]   wr_ptr;
  logic [drb_pkg::BUF_AW:0]   rd_ptr;
  logic [drb_pkg::BUF_AW:0]   next_wr_ptr;
  logic [drb_pkg::BUF_AW:0]   next_rd_ptr;
  logic                       buf_full;
  logic                       buf_empty;
  logic                       do_write;
  logic                       skid_ready;
  logic                       do_read;

  assign buf_full  = (wr_ptr[drb_pkg::BUF_AW] != rd_ptr[drb_pkg::BUF_AW])
                     && (wr_ptr[drb_pkg::BUF_AW-1:0] == rd_ptr[drb_pkg::BUF_AW-1:0]);
  assign buf_empty = (wr_ptr == rd_ptr);
  assign do_write  = lane_valid && !buf_full
                     && ((state == drb_pkg::DRB_WAIT) || (state == drb_pkg::DRB_RUN)
                         || ((state == drb_pkg::DRB_ARMED) && lane_start));
  assign do_read   = (state == drb_pkg::DRB_RUN) && !buf_empty && skid_ready;

  always_comb begin
    next_wr_ptr   = wr_ptr;
    next_rd_ptr   = rd_ptr;
    next_overflow = overflow;
    if (do_write) begin
      next_wr_ptr = wr_ptr + 9'h001;
    end
    if (do_read) begin
      next_rd_ptr = rd_ptr + 9'h001;
    end
    if (state == drb_pkg::DRB_IDLE) begin
      next_wr_ptr   = 9'h000;
      next_rd_ptr   = 9'h000;
    end
    if (reg_write && (reg_addr == drb_pkg::ADDR_STATUS)
        && reg_wdata[drb_pkg::STAT_OVF_BIT]) begin
      next_overflow = 1'b0;
    end
    if (lane_valid && buf_full) begin
      next_overflow = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (do_write) begin
      ebuf[wr_ptr[drb_pkg::BUF_AW-1:0]] <= lane_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr   <= 9'h000;
      rd_ptr   <= 9'h000;
      overflow <= 1'b0;
    end else begin
      wr_ptr   <= next_wr_ptr;
      rd_ptr   <= next_rd_ptr;
      overflow <= next_overflow;
    end
  end

  drb_skid u_skid (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_data   (ebuf[rd_ptr[drb_pkg::BUF_AW-1:0]]),
    .in_valid  (do_read),
    .in_ready  (skid_ready),
    .out_data  (rx_data),
    .out_valid (rx_valid),
    .out_ready (rx_ready)
  );

  a_release_on_offset: assert property (@(posedge clk) disable iff (!reset_n)
    release_pulse |-> $past(mf_cnt) == buffer_release_offset - 6'h01)
    else $error("release not at offset count");
  a_release_period: assert property (@(posedge clk) disable iff (!reset_n)
    release_pulse |-> $past(period_cnt) == release_period)
    else $error("release in wrong multiframe");
  a_no_output_early: assert property (@(posedge clk) disable iff (!reset_n)
    (state != drb_pkg::DRB_RUN) |=> !u_skid.push || release_pulse)
    else $error("data left buffer before release");
  a_frames_limit: assert property (@(posedge clk) disable iff (!reset_n)
    (frames_per_mf > 6'h20) |=> (state == drb_pkg::DRB_IDLE))
    else $error("oversize multiframe accepted");
  a_mf_period: assert property (@(posedge clk) disable iff (!reset_n)
    multiframe_tick && !sysref_edge && !$past(sysref_edge) |-> ##1 !multiframe_tick)
    else $error("multiframe tick too close");
  a_boundary_release: assert property (@(posedge clk) disable iff (!reset_n)
    fire && (buffer_release_offset == frames_per_mf) |-> mf_boundary)
    else $error("full offset not on boundary");
endmodule
`default_nettype wire

// >>> tb/drb_tx_model.sv
// converter transmitter model that sends a counted burst of lane beats
`timescale 1ns/10ps
`default_nettype none
module drb_tx_model (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        go,
  input  wire logic [8:0]  beats,
  output logic [31:0]      lane_data,
  output logic             lane_valid,
  output logic             lane_start
);
  // ----------------------------------------
  // burst sender
  // ----------------------------------------
  logic [8:0] left;
  logic [7:0] idx;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      left       <= 9'h000;
      idx        <= 8'h00;
      lane_valid <= 1'b0;
      lane_start <= 1'b0;
      lane_data  <= 32'h00000000;
    end else if (go && left == 9'h000) begin
      left       <= beats - 9'h001;
      idx        <= 8'h04;
      lane_valid <= 1'b1;
      lane_start <= 1'b1;
      lane_data  <= 32'h03020100;
    end else if (left != 9'h000) begin
      left       <= left - 9'h001;
      idx        <= idx + 8'h04;
      lane_valid <= 1'b1;
      lane_start <= 1'b0;
      lane_data  <= {idx + 8'h03, idx + 8'h02, idx + 8'h01, idx};
    end else begin
      lane_valid <= 1'b0;
      lane_start <= 1'b0;
      // idle lane keeps changing so no stale word looks valid
      lane_data  <= ~lane_data;
    end
  end
endmodule
`default_nettype wire

// >>> tb/drb_release_test.sv
// self-checking bench for the deterministic release buffer
`timescale 1ns/10ps
`default_nettype none
module drb_release_test;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic        clk;
  logic        reset_n;
  logic        sysref;
  logic [31:0] lane_data;
  logic        lane_valid;
  logic        lane_start;
  logic [31:0] rx_data;
  logic        rx_valid;
  logic        rx_ready;
  logic        multiframe_tick;
  logic        release_pulse;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_write;
  logic        reg_read;
  logic [31:0] reg_rdata;
  logic        go;
  logic [8:0]  beats;
  int          failures;
  int          n_tests;
  int          cycles;

  drb_release u_drb_release (.clk(clk), .reset_n(reset_n), .sysref(sysref),
    .lane_data(lane_data), .lane_valid(lane_valid), .lane_start(lane_start),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .multiframe_tick(multiframe_tick), .release_pulse(release_pulse),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata));
  drb_tx_model u_drb_tx_model (.clk(clk), .reset_n(reset_n), .go(go), .beats(beats),
    .lane_data(lane_data), .lane_valid(lane_valid), .lane_start(lane_start));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      wrap_up();
    end
  end
  // ----------------------------------------
  // tasks and scenarios
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata & m, e);
  endtask

  function automatic logic [31:0] exp_beat(input int k);
    logic [7:0] b;
    b = 8'(4 * k);
    return {b + 8'h03, b + 8'h02, b + 8'h01, b};
  endfunction

  task automatic cfg(input int f, input int o, input int n);
    wr(drb_pkg::ADDR_CTRL, 32'h00000000);
    wr(drb_pkg::ADDR_FRAMES, 32'(f));
    wr(drb_pkg::ADDR_OFFSET, 32'(o));
    wr(drb_pkg::ADDR_PERIOD, 32'(n));
    wr(drb_pkg::ADDR_CTRL, 32'h00000001);
    @(posedge clk);
    sysref <= 1'b1;
    @(posedge clk);
    sysref <= 1'b0;
  endtask

  task automatic wait_tick(output int gap);
    gap = 0;
    do begin
      @(posedge clk);
      #1;
      gap++;
    end while (multiframe_tick !== 1'b1 && gap < 100);
  endtask

  task automatic launch(input int f, input int nb);
    int gap;
    wait_tick(gap);
    chk(32'(gap), 32'h00000001);
    wait_tick(gap);
    chk(32'(gap), 32'(f));
    @(posedge clk);
    beats <= 9'(nb);
    go    <= 1'b1;
    @(posedge clk);
    go    <= 1'b0;
  endtask

  task automatic drain(input int ne);
    int got;
    got = 0;
    for (int k = 0; k < 4 * ne + 40 && got < ne; k++) begin
      @(posedge clk);
      rx_ready <= (k % 3 != 2);
      #1;
      if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
        chk(rx_data, exp_beat(got));
        got++;
      end
    end
    chk(32'(got), 32'(ne));
    @(posedge clk);
    rx_ready <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk(32'(rx_valid), 32'h00000000);
  endtask

  task automatic t_reset;
    rd(drb_pkg::ADDR_FRAMES, 32'h0000003F, 32'h00000020);
    rd(drb_pkg::ADDR_OFFSET, 32'h0000003F, 32'h00000020);
    rd(drb_pkg::ADDR_PERIOD, 32'h0000000F, 32'h00000001);
    rd(drb_pkg::ADDR_EARLY, 32'hFFFFFFFF, 32'h00000000);
    rd(drb_pkg::ADDR_EXTRA, 32'h0000FFFF, 32'h00000000);
    rd(drb_pkg::ADDR_LATENCY, 32'hFFFFFFFF, 32'h00000040);
    rd(8'h20, 32'hFFFFFFFF, 32'h00000000);
  endtask

  task automatic t_regs;
    wr(drb_pkg::ADDR_FRAMES, 32'h00000008);
    wr(drb_pkg::ADDR_OFFSET, 32'h00000006);
    wr(drb_pkg::ADDR_PERIOD, 32'h00000002);
    wr(drb_pkg::ADDR_EXTRA, 32'h00000003);
    wr(8'h24, 32'hFFFFFFFF);
    rd(drb_pkg::ADDR_EARLY, 32'hFFFFFFFF, 32'h00000002);
    rd(drb_pkg::ADDR_LATENCY, 32'hFFFFFFFF, 32'h00000019);
    rd(8'h24, 32'hFFFFFFFF, 32'h00000000);
    rd(drb_pkg::ADDR_STATUS, 32'h00000008, 32'h00000008);
  endtask

  task automatic t_release(input int f, input int o, input int n);
    int ticks;
    int last;
    int cyc;
    cfg(f, o, n);
    launch(f, 6);
    ticks = 0;
    last = 0;
    cyc = 0;
    while (release_pulse !== 1'b1 && cyc < 1000) begin
      @(posedge clk);
      #1;
      cyc++;
      if (multiframe_tick === 1'b1 && release_pulse !== 1'b1) begin
        ticks++;
        last = cyc;
      end
    end
    chk(32'(ticks), 32'(n));
    chk(32'(cyc - last), 32'(o));
    chk(32'(multiframe_tick), 32'(o == f));
    drain(6);
    rd(drb_pkg::ADDR_STATUS, 32'h0000000F, 32'h0000000B);
  endtask

  task automatic t_invalid;
    int seen;
    seen = 0;
    cfg(33, 8, 1);
    rd(drb_pkg::ADDR_STATUS, 32'h0000000B, 32'h00000000);
    @(posedge clk);
    beats <= 9'h004;
    go    <= 1'b1;
    @(posedge clk);
    go    <= 1'b0;
    repeat (200) begin
      @(posedge clk);
      #1;
      seen += int'(release_pulse === 1'b1 || rx_valid === 1'b1);
    end
    chk(32'(seen), 32'h00000000);
  endtask

  task automatic t_overflow;
    int cyc;
    cyc = 0;
    cfg(32, 32, 15);
    launch(32, 270);
    repeat (300) @(posedge clk);
    rd(drb_pkg::ADDR_STATUS, 32'h00000004, 32'h00000004);
    wr(drb_pkg::ADDR_STATUS, 32'h00000004);
    rd(drb_pkg::ADDR_STATUS, 32'h00000004, 32'h00000000);
    while (release_pulse !== 1'b1 && cyc < 1000) begin
      @(posedge clk);
      #1;
      cyc++;
    end
    drain(drb_pkg::BUF_DEPTH);
  endtask

  initial begin
    failures  = 0;
    n_tests   = 0;
    cycles    = 0;
    reset_n   = 1'b0;
    sysref    = 1'b0;
    rx_ready  = 1'b1;
    reg_addr  = 8'h00;
    reg_wdata = 32'h00000000;
    reg_write = 1'b0;
    reg_read  = 1'b0;
    go        = 1'b0;
    beats     = 9'h000;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_regs();
    t_release(8, 8, 1);
    t_release(8, 6, 2);
    t_release(6, 3, 3);
    t_invalid();
    t_overflow();
    wrap_up();
  end
endmodule
`default_nettype wire
